// file: src/patu_top.sv
// paged address translation unit: translation cache, table walker, apb registers
`timescale 1ns/1ps
module patu_top
  import patu_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  pprot,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core access and bus controller answer
  input  wire patu_req_t   core_req,
  input  wire logic        core_cache_hit,
  input  wire logic        translation_disable_in,
  output patu_resp_t       bus_resp,
  output logic             miss_abort,
  output logic             cache_inhibit_out,
  // table walk memory port
  output patu_mreq_t       mem,
  input  wire logic        mem_ack,
  input  wire logic        mem_berr,
  input  wire logic [31:0] mem_rdata
);
  // =====================================================
  // registers
  logic [31:0] crp_q, srp_q, tc_q, tt0_q, tt1_q, stat_q, tla_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q, miss_q, ci_q;
  patu_resp_t  resp_q;
  patu_mreq_t  mem_q;
  patu_state_t st_q;
  // =====================================================
  // walker state
  logic [31:0] la_q, rem_q, base_q, pg_q;
  logic [2:0]  fc_q, widx_q, lvl_q;
  logic [5:0]  used_q;
  logic [1:0]  dt_q;
  logic        wr_q, test_q, fcsel_q, wp_q, fail_q, inv_q, ci_w_q, mod_q;
  // =====================================================
  // translation cache
  logic [31:0]     e_la_q [NENT];
  logic [31:0]     e_pa_q [NENT];
  logic [2:0]      e_fc_q [NENT];
  logic [AGEW-1:0] e_age_q[NENT];
  logic [NENT-1:0] e_val_q, e_wp_q, e_ci_q, e_mod_q;

  // =====================================================
  // apb decode
  logic acc, bad, wr_fire, test_go, flush;
  logic [31:0] rd_d;
  assign acc = psel & penable;
  always_comb
  begin
    bad  = ~pprot[0] | (paddr[31:5] != 27'h0) | (paddr[1:0] != 2'h0);
    rd_d = RST_ZERO;
    case (paddr[7:0])
      OFF_CPU_ROOT: rd_d = crp_q;
      OFF_SUP_ROOT: rd_d = srp_q;
      OFF_XCTRL:    rd_d = tc_q;
      OFF_TT0:      rd_d = tt0_q;
      OFF_TT1:      rd_d = tt1_q;
      OFF_STATUS:   rd_d = stat_q | (32'(st_q != S_IDLE) << ST_BUSY);
      OFF_TEST_LA:  rd_d = tla_q;
      OFF_TEST_CMD: rd_d = RST_ZERO;
      default:      rd_d = RST_ZERO;
    endcase
  end
  assign wr_fire = acc & pready_q & pwrite & ~bad;
  assign test_go = wr_fire & (paddr[7:0] == OFF_TEST_CMD) & (st_q == S_IDLE);
  assign flush   = wr_fire & (paddr[7:0] <= OFF_XCTRL);

  // one wait state: answer comes in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RST_ZERO;
    end
    else
    begin
      pready_q <= acc & ~pready_q;
      if (acc & ~pready_q)
      begin
        pslverr_q <= bad;
        prdata_q  <= (bad | pwrite) ? RST_ZERO : rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crp_q <= RST_ZERO;
      srp_q <= RST_ZERO;
      tc_q  <= RST_ZERO;
      tt0_q <= RST_ZERO;
      tt1_q <= RST_ZERO;
      tla_q <= RST_ZERO;
    end
    else if (wr_fire)
    begin
      case (paddr[7:0])
        OFF_CPU_ROOT: crp_q <= pwdata;
        OFF_SUP_ROOT: srp_q <= pwdata;
        OFF_XCTRL:    tc_q  <= pwdata;
        OFF_TT0:      tt0_q <= pwdata;
        OFF_TT1:      tt1_q <= pwdata;
        OFF_TEST_LA:  tla_q <= pwdata;
        default:      tla_q <= tla_q;
      endcase
    end
  end

  // =====================================================
  // configuration checks
  logic [3:0]  f_is, f_ps, f_a, f_b, f_c, f_d, tiw;
  logic [6:0]  sum;
  logic        cfg_ok, xl_on;
  logic [31:0] pmask, low;
  assign f_is = tc_q[TC_IS+:4];
  assign f_ps = tc_q[TC_PS+:4];
  assign f_a  = tc_q[TC_TIA+:4];
  assign f_b  = tc_q[TC_TIB+:4];
  assign f_c  = (f_b != 4'h0) ? tc_q[TC_TIC+:4] : 4'h0;
  assign f_d  = (f_c != 4'h0) ? tc_q[TC_TID+:4] : 4'h0;
  assign sum  = 7'(f_is) + 7'(f_ps) + 7'(f_a) + 7'(f_b) + 7'(f_c) + 7'(f_d);
  assign cfg_ok = (sum == TC_SUM) & (f_a != 4'h0);
  assign xl_on  = tc_q[TC_EN] & cfg_ok & ~translation_disable_in;
  assign pmask  = 32'hffff_ffff << f_ps;
  assign low    = 32'hffff_ffff >> used_q;
  always_comb
  begin
    case (widx_q)
      3'd0:    tiw = f_a;
      3'd1:    tiw = f_b;
      3'd2:    tiw = f_c;
      3'd3:    tiw = f_d;
      default: tiw = 4'h0;
    endcase
  end

  // =====================================================
  // transparent blocks
  function automatic logic tt_hit(input logic [31:0] t, input patu_req_t r);
    logic a_ok, f_ok, d_ok;
    a_ok = ((r.la[31:24] ^ t[TT_BASE+:8]) & ~t[TT_MASK+:8]) == 8'h00;
    f_ok = ((r.fc ^ t[TT_FCB+:3]) & ~t[TT_FCM+:3]) == 3'h0;
    d_ok = t[TT_RWM] | (t[TT_RW] == ~r.wr);
    return t[TT_EN] & a_ok & f_ok & d_ok;
  endfunction
  logic tt0_m, tt1_m;
  assign tt0_m = tt_hit(tt0_q, core_req);
  assign tt1_m = tt_hit(tt1_q, core_req);

  // =====================================================
  // parallel tag compare and victim choice
  logic [NENT-1:0] hit_v;
  logic [4:0]      hit_i, vic_i;
  logic            hit;
  always_comb
  begin
    hit   = 1'b0;
    hit_i = 5'h0;
    vic_i = 5'h0;
    for (int i = 0; i < NENT; i++)
    begin
      hit_v[i] = e_val_q[i] & (e_fc_q[i] == core_req.fc)
               & (e_la_q[i] == (core_req.la & pmask));
      if (hit_v[i])
      begin
        hit   = 1'b1;
        hit_i = 5'(i);
      end
      if (!e_val_q[vic_i])
        vic_i = vic_i;
      else if (!e_val_q[i] || e_age_q[i] > e_age_q[vic_i])
        vic_i = 5'(i);
    end
  end

  // =====================================================
  // access decision and walker
  logic        take, start, use_srp, more;
  logic [31:0] root, pa_w, idx, nxt;
  assign take    = (st_q == S_IDLE) & core_req.valid & ~resp_q.valid & ~test_go;
  assign use_srp = tc_q[TC_SRE] & fc_q[2];
  assign root    = use_srp ? srp_q : crp_q;
  assign more    = (widx_q < 3'd4) & (tiw != 4'h0);
  assign idx     = fcsel_q ? {29'h0, fc_q} : (rem_q >> (6'd32 - {2'b0, tiw}));
  assign nxt     = base_q + (idx << ((dt_q == DT_TBL4) ? 2 : 3));
  assign pa_w    = (mem_rdata & ~low) | (la_q & low);
  assign start   = test_go | (take & xl_on & ~tt0_m & ~tt1_m & ~(core_cache_hit & ~core_req.wr)
                   & ~(hit & ~(core_req.wr & ~e_mod_q[hit_i])));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= S_IDLE;
      resp_q  <= '0;
      mem_q   <= '0;
      miss_q  <= 1'b0;
      ci_q    <= 1'b0;
      la_q    <= RST_ZERO;
      rem_q   <= RST_ZERO;
      base_q  <= RST_ZERO;
      pg_q    <= RST_ZERO;
      fc_q    <= 3'h0;
      widx_q  <= 3'h0;
      lvl_q   <= 3'h0;
      used_q  <= 6'h0;
      dt_q    <= 2'h0;
      wr_q    <= 1'b0;
      test_q  <= 1'b0;
      fcsel_q <= 1'b0;
      wp_q    <= 1'b0;
      fail_q  <= 1'b0;
      inv_q   <= 1'b0;
      ci_w_q  <= 1'b0;
      mod_q   <= 1'b0;
    end
    else
    begin
      resp_q.valid <= 1'b0;
      miss_q       <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (take & ~start)
          begin
            resp_q.valid <= 1'b1;
            resp_q.fc    <= core_req.fc;
            resp_q.berr  <= 1'b0;
            resp_q.pa    <= core_req.la;
            resp_q.ci    <= 1'b0;
            if (tt0_m | tt1_m | ~xl_on)
              resp_q.ci <= (tt0_m & tt0_q[TT_CI]) | (tt1_m & tt1_q[TT_CI]);
            else
            begin
              resp_q.pa   <= e_pa_q[hit_i] | (core_req.la & ~pmask);
              resp_q.ci   <= e_ci_q[hit_i];
              resp_q.berr <= e_wp_q[hit_i] & core_req.wr;
            end
            resp_q.abort <= (core_req_wp_fail(hit_i)) | (core_cache_hit & ~core_req.wr);
          end
          if (start)
          begin
            miss_q  <= ~test_go;
            test_q  <= test_go;
            la_q    <= test_go ? tla_q : core_req.la;
            fc_q    <= test_go ? pwdata[2:0] : core_req.fc;
            wr_q    <= test_go ? pwdata[3] : core_req.wr;
            rem_q   <= (test_go ? tla_q : core_req.la) << f_is;
            used_q  <= 6'(f_is);
            widx_q  <= 3'h0;
            lvl_q   <= 3'h0;
            fcsel_q <= tc_q[TC_FCL];
            wp_q    <= 1'b0;
            fail_q  <= 1'b0;
            inv_q   <= 1'b0;
            st_q    <= S_ISSUE;
          end
        end
        S_ISSUE:
        begin
          if (lvl_q == 3'h0)
          begin
            base_q <= {root[31:4], 4'h0};
            dt_q   <= root[1:0];
            lvl_q  <= 3'h1;
            if (root[1:0] == DT_PAGE)
            begin
              pg_q   <= ({root[31:4], 4'h0} & ~low) | (la_q & low) & pmask;
              ci_w_q <= root[D_CI];
              mod_q  <= 1'b1;
              st_q   <= S_DONE;
            end
            else if (root[1:0] == DT_INVALID)
            begin
              fail_q <= 1'b1;
              inv_q  <= 1'b1;
              st_q   <= S_DONE;
            end
          end
          else
          begin
            mem_q <= '{req: 1'b1, we: 1'b0, addr: nxt, wdata: RST_ZERO};
            if (!fcsel_q)
            begin
              rem_q  <= rem_q << tiw;
              used_q <= used_q + 6'(tiw);
              widx_q <= widx_q + 3'h1;
            end
            fcsel_q <= 1'b0;
            st_q    <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          if (mem_ack)
          begin
            mem_q.req <= 1'b0;
            lvl_q     <= lvl_q + 3'h1;
            wp_q      <= wp_q | mem_rdata[D_WP];
            if (mem_berr || mem_rdata[1:0] == DT_INVALID)
            begin
              fail_q <= 1'b1;
              inv_q  <= ~mem_berr;
              st_q   <= S_DONE;
            end
            else if (mem_rdata[1:0] == DT_PAGE)
            begin
              pg_q   <= pa_w & pmask;
              ci_w_q <= mem_rdata[D_CI];
              mod_q  <= mem_rdata[D_M] | wr_q;
              if (!test_q && (!mem_rdata[D_U] || (wr_q && !mem_rdata[D_M])))
              begin
                mem_q.req <= 1'b1;
                mem_q.we  <= 1'b1;
                mem_q.wdata <= mem_rdata | (32'h1 << D_U) | (32'(wr_q) << D_M);
                st_q      <= S_HIST;
              end
              else
                st_q <= S_DONE;
            end
            else if (more)
            begin
              base_q <= {mem_rdata[31:4], 4'h0};
              dt_q   <= mem_rdata[1:0];
              st_q   <= S_ISSUE;
            end
            else
            begin
              fail_q <= 1'b1;
              inv_q  <= 1'b1;
              st_q   <= S_DONE;
            end
          end
        end
        S_HIST:
        begin
          if (mem_ack)
          begin
            mem_q <= '0;
            st_q  <= S_DONE;
          end
        end
        S_DONE:
        begin
          if (!test_q)
          begin
            resp_q.valid <= 1'b1;
            resp_q.pa    <= pg_q | (la_q & ~pmask);
            resp_q.fc    <= fc_q;
            resp_q.ci    <= ci_w_q;
            resp_q.berr  <= fail_q | (wp_q & wr_q);
            resp_q.abort <= fail_q | (wp_q & wr_q);
          end
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
      if (take & ~start)
        ci_q <= tt0_m | tt1_m | ~xl_on ? ((tt0_m & tt0_q[TT_CI]) | (tt1_m & tt1_q[TT_CI]))
                                       : e_ci_q[hit_i];
      else if (st_q == S_DONE && !test_q)
        ci_q <= ci_w_q;
    end
  end

  function automatic logic core_req_wp_fail(input logic [4:0] i);
    return xl_on & ~tt0_m & ~tt1_m & e_wp_q[i] & core_req.wr;
  endfunction

  // =====================================================
  // test translation status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_q <= RST_ZERO;
    else if (test_go)
      stat_q <= RST_ZERO;
    else if (st_q == S_DONE && test_q)
    begin
      stat_q[ST_BERR]    <= fail_q & ~inv_q;
      stat_q[ST_INV]     <= inv_q;
      stat_q[ST_WP]      <= wp_q;
      stat_q[ST_MOD]     <= mod_q & ~fail_q;
      stat_q[ST_TT]      <= 1'b0;
      stat_q[ST_LVL+:3]  <= lvl_q - 3'h1;
    end
  end

  // =====================================================
  // entry refill and age tracking
  logic       load, touch;
  logic [4:0] t_i;
  assign load  = (st_q == S_DONE) & ~test_q & ~fail_q;
  assign touch = load | (take & ~start & xl_on & ~tt0_m & ~tt1_m & hit);
  assign t_i   = load ? vic_i : hit_i;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      e_val_q <= '0;
      e_wp_q  <= '0;
      e_ci_q  <= '0;
      e_mod_q <= '0;
      for (int i = 0; i < NENT; i++)
      begin
        e_la_q[i]  <= RST_ZERO;
        e_pa_q[i]  <= RST_ZERO;
        e_fc_q[i]  <= 3'h0;
        e_age_q[i] <= '0;
      end
    end
    else if (flush)
      e_val_q <= '0;
    else
    begin
      if (touch)
        for (int i = 0; i < NENT; i++)
          if (5'(i) == t_i)
            e_age_q[i] <= '0;
          else if (e_age_q[i] != '1)
            e_age_q[i] <= e_age_q[i] + 1'b1;
      if (load)
      begin
        e_val_q[vic_i] <= 1'b1;
        e_la_q[vic_i]  <= la_q & pmask;
        e_pa_q[vic_i]  <= pg_q;
        e_fc_q[vic_i]  <= fc_q;
        e_wp_q[vic_i]  <= wp_q;
        e_ci_q[vic_i]  <= ci_w_q;
        e_mod_q[vic_i] <= mod_q;
      end
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign bus_resp          = resp_q;
  assign miss_abort        = miss_q;
  assign cache_inhibit_out = ci_q;
  assign mem               = mem_q;
endmodule

// file: pkg/patu_pkg.sv
// shared constants and types of the paged address translation unit
package patu_pkg;
  // =====================================================
  // register map (byte offsets)
  localparam logic [7:0] OFF_CPU_ROOT = 8'h00;
  localparam logic [7:0] OFF_SUP_ROOT = 8'h04;
  localparam logic [7:0] OFF_XCTRL    = 8'h08;
  localparam logic [7:0] OFF_TT0      = 8'h0c;
  localparam logic [7:0] OFF_TT1      = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_TEST_LA  = 8'h18;
  localparam logic [7:0] OFF_TEST_CMD = 8'h1c;
  // =====================================================
  // translation_control fields
  localparam int TC_EN  = 31;
  localparam int TC_SRE = 25;
  localparam int TC_FCL = 24;
  localparam int TC_PS  = 20;
  localparam int TC_IS  = 16;
  localparam int TC_TIA = 12;
  localparam int TC_TIB = 8;
  localparam int TC_TIC = 4;
  localparam int TC_TID = 0;
  localparam logic [6:0] TC_SUM = 7'h20;
  // =====================================================
  // transparent block fields
  localparam int TT_BASE = 24;
  localparam int TT_MASK = 16;
  localparam int TT_EN   = 15;
  localparam int TT_CI   = 10;
  localparam int TT_RW   = 9;
  localparam int TT_RWM  = 8;
  localparam int TT_FCB  = 4;
  localparam int TT_FCM  = 0;
  // =====================================================
  // descriptor fields and types
  localparam logic [1:0] DT_INVALID = 2'h0;
  localparam logic [1:0] DT_PAGE    = 2'h1;
  localparam logic [1:0] DT_TBL4    = 2'h2;
  localparam int D_WP = 2;
  localparam int D_U  = 3;
  localparam int D_M  = 4;
  localparam int D_CI = 6;
  // =====================================================
  // status fields
  localparam int ST_BERR = 15;
  localparam int ST_WP   = 11;
  localparam int ST_INV  = 10;
  localparam int ST_MOD  = 9;
  localparam int ST_TT   = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_LVL  = 0;
  // =====================================================
  // sizes and reset values
  localparam int NENT = 22;
  localparam int AGEW = 5;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // =====================================================
  // types
  typedef struct packed {
    logic        valid;
    logic [31:0] la;
    logic [2:0]  fc;
    logic        wr;
  } patu_req_t;
  typedef struct packed {
    logic        valid;
    logic [31:0] pa;
    logic [2:0]  fc;
    logic        ci;
    logic        abort;
    logic        berr;
  } patu_resp_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } patu_mreq_t;
  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_ISSUE = 5'b00010,
    S_FETCH = 5'b00100,
    S_HIST  = 5'b01000,
    S_DONE  = 5'b10000
  } patu_state_t;
endpackage

// file: bench/patu_asserts.sv
// checker of the translation unit ports
`timescale 1ns/1ps
module patu_asserts
  import patu_pkg::*;
(
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [2:0] pprot,
  input wire logic       pready,
  input wire logic       pslverr,
  // core side
  input wire patu_req_t  core_req,
  input wire logic       core_cache_hit,
  input wire logic       translation_disable_in,
  input wire patu_resp_t bus_resp,
  input wire logic       miss_abort,
  input wire logic       cache_inhibit_out,
  // walk port
  input wire patu_mreq_t mem,
  input wire logic       mem_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // core access
  property p_fc_pass; bus_resp.valid |-> bus_resp.fc == core_req.fc; endproperty
  a_fc_pass: assert property (p_fc_pass) else $error("function code altered");
  property p_dis_pass;
    bus_resp.valid && !bus_resp.abort && $past(translation_disable_in) |->
      bus_resp.pa == core_req.la;
  endproperty
  a_dis_pass: assert property (p_dis_pass) else $error("address translated");
  property p_chit_abort;
    bus_resp.valid && !core_req.wr && core_cache_hit |-> bus_resp.abort;
  endproperty
  a_chit_abort: assert property (p_chit_abort) else $error("cached read ran");
  property p_miss_walk;
    miss_abort |-> !bus_resp.valid ##1 !bus_resp.valid ##[0:4] (mem.req || bus_resp.valid);
  endproperty
  a_miss_walk: assert property (p_miss_walk) else $error("miss without walk");
  property p_valid_pulse; bus_resp.valid |=> !bus_resp.valid; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("answer too long");
  property p_ci_hold; bus_resp.valid ##1 1'b1 |-> cache_inhibit_out == $past(bus_resp.ci);
  endproperty
  a_ci_hold: assert property (p_ci_hold) else $error("inhibit output wrong");
  property p_mem_hold; mem.req && !mem_ack |=> mem.req && $stable(mem.addr); endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("walk request dropped");
  // ==========================================
  // register bus
  property p_priv; pready && !pprot[0] |-> pslverr; endproperty
  a_priv: assert property (p_priv) else $error("user access accepted");
  property p_one_wait; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count");
  c_miss: cover property (miss_abort);
  c_err: cover property (pready && pslverr);
  c_ci: cover property (bus_resp.valid && bus_resp.ci);
endmodule

// file: bench/patu_mem_model.sv
// descriptor memory answering the table walker
`timescale 1ns/1ps
module patu_mem_model
  import patu_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // walk port
  input  wire patu_mreq_t  mem,
  output logic             mem_ack,
  output logic             mem_berr,
  output logic      [31:0] mem_rdata
);
  logic [31:0] word_q [256];
  logic [1:0]  wait_q;
  logic        slow_q;
  // ==========================================
  // tree: level a at 0x100, level b at 0x200
  initial
  begin
    for (int i = 0; i < 256; i++)
      word_q[i] = 32'h0;
    for (int a = 0; a < 8; a++)
    begin
      word_q[64 + a] = 32'h0000_0202 + 32'(a * 32);
      for (int b = 0; b < 8; b++)
        word_q[128 + a * 8 + b] = {20'h80000 + 20'(a * 8 + b), 5'h0, b == 7, 6'h01};
    end
    word_q[70] = 32'h9000_0001;
    word_q[71] = 32'h0;
  end
  // alternate prompt and slow answers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_ack   <= 1'b0;
      mem_berr  <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q    <= 2'h0;
      slow_q    <= 1'b0;
    end
    else if (mem_ack)
    begin
      // released data shows the inverse, never the stale word
      mem_ack   <= 1'b0;
      mem_berr  <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q    <= slow_q ? 2'h3 : 2'h0;
    end
    else if (mem.req && wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else if (mem.req)
    begin
      mem_ack   <= 1'b1;
      mem_berr  <= |mem.addr[31:10];
      mem_rdata <= word_q[mem.addr[9:2]];
      slow_q    <= ~slow_q;
      if (mem.we)
        word_q[mem.addr[9:2]] <= mem.wdata;
    end
  end
endmodule

// file: bench/patu_top_tb.sv
// self-checking bench of the translation unit
`timescale 1ns/1ps
module patu_top_tb
  import patu_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, mem_rdata;
  logic [2:0]  pprot = 3'h1;
  logic        pready, pslverr, miss_abort, cache_inhibit_out, mem_ack, mem_berr;
  logic        core_cache_hit = 1'b0, translation_disable_in = 1'b0;
  patu_req_t   core_req = '0;
  patu_resp_t  bus_resp;
  patu_mreq_t  mem;
  int          fails = 0, cmp_count = 0;
  always #20 pclk = ~pclk;
  patu_top DUT (.*);
  patu_mem_model u_mem (.*);
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic hang(input logic stuck);
    if (stuck)
    begin
      fails++;
      $display("unexpected at %0t: no answer", $time);
      print_verdict();
    end
  endtask
  // ==========================================
  // bus tasks, entered just after a rising edge
  task automatic apb(input logic we, input logic [31:0] a, d, input logic [2:0] pr,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    pprot <= pr;
    @(posedge pclk);
    penable <= 1'b1;
    // sampled at the edge: the answer is taken where the slave sees it
    for (int n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    hang(pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, {24'h0, a}, d, 3'h1, rd, er);
    cmp_bit(er, 1'b0);
  endtask
  task automatic access(input logic [31:0] la, input logic [2:0] fc, input logic w, ch,
                        output patu_resp_t r, output logic m);
    m = 1'b0;
    core_req <= '{1'b1, la, fc, w};
    core_cache_hit <= ch;
    for (int n = 0; n < 200; n++)
    begin
      @(posedge pclk);
      m |= miss_abort;
      if (bus_resp.valid === 1'b1)
        break;
    end
    hang(bus_resp.valid !== 1'b1);
    r = bus_resp;
    core_req.valid <= 1'b0;
    @(posedge pclk);
  endtask
  // {berr, ci, pa} for the tree held by the memory model
  function automatic logic [33:0] exp_xl(input logic [31:0] la);
    if (la[17:15] == 3'h7)
      return {2'b10, 32'h0};
    if (la[17:15] == 3'h6)
      return {2'b00, 17'h12000, la[14:0]};
    return {1'b0, la[14:12] == 3'h7, 20'h80000 + {14'h0, la[17:12]}, la[11:0]};
  endfunction
  // ==========================================
  // main sequence
  initial
  begin
    logic [31:0] la, rd;
    logic [33:0] x;
    logic        er, m;
    patu_resp_t  r;
    void'($urandom(32'h56ebea9c));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, 32'(i * 4), 32'h0, 3'h1, rd, er);
      cmp_word(rd, RST_ZERO);
      cmp_bit(er, i == 8);
    end
    wr(OFF_CPU_ROOT, 32'h0000_0102);
    wr(OFF_SUP_ROOT, 32'ha000_0001);
    wr(OFF_XCTRL, 32'h82ce_3300);
    apb(1'b0, {24'h0, OFF_XCTRL}, 32'h0, 3'h1, rd, er);
    cmp_word(rd, 32'h82ce_3300);
    apb(1'b1, {24'h0, OFF_CPU_ROOT}, 32'h0, 3'h0, rd, er);
    cmp_bit(er, 1'b1);
    $display("registers done");
    for (int i = 0; i < 40; i++)
    begin
      if (!i[0])
        la = {8'h00, 24'($urandom)};
      access(la, {1'b0, la[1:0]}, !i[0] && 1'($urandom), 1'b0, r, m);
      x = exp_xl(la);
      if (i == 0 || (i[0] && !x[33]))
        cmp_bit(m, i == 0);
      cmp_bit(r.berr, x[33]);
      cmp_word({29'h0, r.fc}, {29'h0, 1'b0, la[1:0]});
      if (!x[33])
      begin
        cmp_word(r.pa, x[31:0]);
        cmp_bit(r.ci, x[32]);
        cmp_bit(u_mem.word_q[la[17:15] == 3'h6 ? 8'd70 : {2'b10, la[17:12]}][D_U], 1'b1);
      end
    end
    access(la, 3'h1, 1'b0, 1'b1, r, m);
    cmp_bit(r.abort, 1'b1);
    la = {8'h00, 24'($urandom)};
    access(la, 3'h5, 1'b0, 1'b0, r, m);
    cmp_word(r.pa, {14'h2800, la[17:0]});
    // first level indexed by function code, then one address level ending early
    wr(OFF_XCTRL, 32'h83ce_3300);
    la = {8'h00, 24'($urandom)};
    access(la, {1'b0, la[1:0]}, 1'b0, 1'b0, r, m);
    cmp_word(r.pa, {14'h2000, 1'b0, la[1:0], la[14:0]});
    cmp_bit(r.ci, la[17:15] == 3'h7);
    wr(OFF_XCTRL, 32'h82ce_3300);
    $display("translation done");
    translation_disable_in <= 1'b1;
    la = $urandom;
    access(la, 3'h2, 1'b0, 1'b0, r, m);
    cmp_word(r.pa, la);
    translation_disable_in <= 1'b0;
    wr(OFF_TT0, 32'h4000_8507);
    la = {8'h40, 24'($urandom)};
    access(la, 3'($urandom), 1'b1, 1'b0, r, m);
    cmp_word(r.pa, la);
    cmp_bit(r.ci, 1'b1);
    $display("bypass done");
    for (int k = 0; k < 2; k++)
    begin
      wr(OFF_TEST_LA, {14'h0, k[0] ? 3'h7 : 3'h2, 15'h0});
      wr(OFF_TEST_CMD, 32'h1);
      rd = 32'hffff_ffff;
      for (int n = 0; n < 50 && rd[ST_BUSY] !== 1'b0; n++)
        apb(1'b0, {24'h0, OFF_STATUS}, 32'h0, 3'h1, rd, er);
      hang(rd[ST_BUSY] !== 1'b0);
      cmp_bit(rd[ST_INV], k[0]);
      if (!k[0])
        cmp_word({29'h0, rd[2:0]}, 32'h2);
    end
    $display("test translation done");
    print_verdict();
  end
endmodule
bind patu_top patu_asserts u_chk (.*);
